// >>> mrc_params.svh
// Constants of the reset sequencer: register map, field positions,
// reset values, accepted threshold codes and timing counts.
// Assumes a 20 MHz system clock.
`ifndef MRC_PARAMS_SVH
`define MRC_PARAMS_SVH

// Register byte offsets
`define MRC_ADDR_CAUSE 8'h00
`define MRC_ADDR_THRESH 8'h04
`define MRC_ADDR_STATUS 8'h08
`define MRC_ADDR_IRQ_STAT 8'h0c
`define MRC_ADDR_IRQ_MASK 8'h10
`define MRC_ADDR_PORT_DATA 8'h14
`define MRC_ADDR_PORT_DIR 8'h18

// reset_cause_flags fields
`define MRC_CAUSE_SYSCLK 7
`define MRC_CAUSE_LOWSUP 2
`define MRC_CAUSE_FAULT 1
`define MRC_CAUSE_WDTCTL 0

// Status fields
`define MRC_STATUS_TO 5
`define MRC_STATUS_PDF 4

// Interrupt status / mask fields
`define MRC_IRQ_W 4
`define MRC_IRQ_LOWSUP 0
`define MRC_IRQ_FAULT 1
`define MRC_IRQ_WDT 2
`define MRC_IRQ_WDTCTL 3

// Accepted threshold codes and reset values
`define MRC_CODE_2V10 8'h55
`define MRC_CODE_2V55 8'h33
`define MRC_CODE_3V15 8'h99
`define MRC_CODE_3V80 8'haa
`define MRC_THRESH_POR 8'h55
`define MRC_PORT_POR 8'hff

// Bus encodings
`define MRC_HSIZE_WORD 3'b010
`define MRC_ZERO32 32'h0000_0000

// Timing
`define MRC_CLK_HZ 20000000
`define MRC_POR_DELAY_MS 50
`define MRC_POR_DELAY_CYC (`MRC_POR_DELAY_MS * (`MRC_CLK_HZ / 1000))
`define MRC_QUAL_TIME_US 100
`define MRC_QUAL_CYC (`MRC_QUAL_TIME_US * (`MRC_CLK_HZ / 1000000))
`define MRC_FAULT_TICKS 2'd3
`define MRC_CNT_W 20

`endif

// >>> mrc_pkg.sv
// Types shared by the reset sequencer.
// Constants live in mrc_params.svh.
package mrc_pkg;

    typedef enum logic [1:0] {
        MRC_ST_POR = 2'b00,
        MRC_ST_RUN = 2'b01,
        MRC_ST_FAULT = 2'b10,
        MRC_ST_HOLD = 2'b11
    } mrc_state_t;

endpackage : mrc_pkg

// >>> mrc_reset_ctrl.sv
// Reset sequencer of a small 8-bit microcontroller, AHB-Lite slave.
// Assumes a comparator flag for the low supply, the slow RC clock as an
// asynchronous input, and watchdog/halt events from core logic on hclk.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "mrc_params.svh"

module mrc_reset_ctrl #(
    parameter int unsigned POR_CYCLES = `MRC_POR_DELAY_CYC,
    parameter int unsigned QUAL_CYCLES = `MRC_QUAL_CYC
) (
    // Clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    // Analog and slow clock inputs
    input wire logic low_supply_in,
    input wire logic slow_internal_rc,
    // Core events on hclk
    input wire logic wdt_timeout,
    input wire logic wdt_ctrl_fault,
    input wire logic sleep_mode,
    input wire logic halt_exec,
    input wire logic clr_wdt,
    // Reset outputs
    output logic core_rst_n,
    output logic ctx_clear,
    // Preset registers
    output logic [7:0] threshold_code,
    output logic idle_sysclk_keep,
    output logic [7:0] port_data,
    output logic [7:0] port_dir
);

    function automatic logic code_ok(input logic [7:0] c);
        return (c == `MRC_CODE_2V10) || (c == `MRC_CODE_2V55) ||
               (c == `MRC_CODE_3V15) || (c == `MRC_CODE_3V80);
    endfunction : code_ok

    function automatic logic cnt_hit(input logic [`MRC_CNT_W-1:0] c,
                                     input int unsigned lim);
        return (32'(c) + 32'h0000_0001) >= lim;
    endfunction : cnt_hit

    function automatic logic sticky(input logic f, input logic set,
                                    input logic clr);
        return set | (f & ~clr);
    endfunction : sticky

    mrc_pkg::mrc_state_t state_reg, state_next;
    logic [`MRC_CNT_W-1:0] cnt_reg, cnt_next;
    logic [`MRC_CNT_W-1:0] qual_reg, qual_next;
    logic [1:0] rc_cnt_reg, rc_cnt_next;
    logic ls_s1_reg, ls_s2_reg, ls_s3_reg, ls_filt_reg;
    logic rc_s1_reg, rc_s2_reg, rc_s3_reg, rc_filt_reg, rc_prev_reg;
    logic fault_src_reg;
    logic [7:0] thresh_reg;
    logic sysclk_reg, lowsup_reg, fault_reg, wdtctl_reg;
    logic to_reg, pdf_reg;
    logic [7:0] pdata_reg, pdir_reg;
    logic [`MRC_IRQ_W-1:0] istat_reg, imask_reg, istat_set;
    logic core_rst_n_reg, ctx_clear_reg;
    logic dp_wr_reg, dp_rd_reg;
    logic [7:0] dp_addr_reg;
    logic [31:0] hrdata_reg;

    // Bus decode
    wire ap_valid = hsel & htrans[1] & hready & (hsize == `MRC_HSIZE_WORD);
    wire wr_cause = dp_wr_reg & (dp_addr_reg == `MRC_ADDR_CAUSE);
    wire wr_thresh = dp_wr_reg & (dp_addr_reg == `MRC_ADDR_THRESH);
    wire wr_istat = dp_wr_reg & (dp_addr_reg == `MRC_ADDR_IRQ_STAT);
    wire wr_imask = dp_wr_reg & (dp_addr_reg == `MRC_ADDR_IRQ_MASK);
    wire wr_pdata = dp_wr_reg & (dp_addr_reg == `MRC_ADDR_PORT_DATA);
    wire wr_pdir = dp_wr_reg & (dp_addr_reg == `MRC_ADDR_PORT_DIR);

    // Sequencer events
    wire running = (state_reg == mrc_pkg::MRC_ST_RUN) ||
                   (state_reg == mrc_pkg::MRC_ST_FAULT);
    wire mon_active = ls_filt_reg & ~sleep_mode & running;
    wire lvr_fire = mon_active & cnt_hit(qual_reg, QUAL_CYCLES);
    wire rc_edge = rc_filt_reg & ~rc_prev_reg;
    wire fault_req = (state_reg == mrc_pkg::MRC_ST_RUN) &
                     (~code_ok(thresh_reg) | wdt_ctrl_fault);
    wire fault_done = (state_reg == mrc_pkg::MRC_ST_FAULT) & rc_edge &
                      (rc_cnt_reg == (`MRC_FAULT_TICKS - 2'd1));
    wire wdt_full = running & wdt_timeout & ~sleep_mode;
    wire wdt_sleep = running & wdt_timeout & sleep_mode;
    wire enter_hold = (state_reg != mrc_pkg::MRC_ST_HOLD) &
                      (state_next == mrc_pkg::MRC_ST_HOLD);
    wire fault_load = fault_done & ~lvr_fire & ~wdt_full;
    wire keep_thresh = lvr_fire;

    // Synchronisers: a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_s1_reg <= 1'b0;
            ls_s2_reg <= 1'b0;
            ls_s3_reg <= 1'b0;
            ls_filt_reg <= 1'b0;
            rc_s1_reg <= 1'b0;
            rc_s2_reg <= 1'b0;
            rc_s3_reg <= 1'b0;
            rc_filt_reg <= 1'b0;
            rc_prev_reg <= 1'b0;
        end else begin
            ls_s1_reg <= low_supply_in;
            ls_s2_reg <= ls_s1_reg;
            ls_s3_reg <= ls_s2_reg;
            if (ls_s2_reg == ls_s3_reg) begin
                ls_filt_reg <= ls_s3_reg;
            end
            rc_s1_reg <= slow_internal_rc;
            rc_s2_reg <= rc_s1_reg;
            rc_s3_reg <= rc_s2_reg;
            if (rc_s2_reg == rc_s3_reg) begin
                rc_filt_reg <= rc_s3_reg;
            end
            rc_prev_reg <= rc_filt_reg;
        end
    end

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            mrc_pkg::MRC_ST_POR: begin
                if (cnt_hit(cnt_reg, POR_CYCLES)) begin
                    state_next = mrc_pkg::MRC_ST_RUN;
                end
            end
            mrc_pkg::MRC_ST_RUN: begin
                if (lvr_fire || wdt_full) begin
                    state_next = mrc_pkg::MRC_ST_HOLD;
                end else if (fault_req) begin
                    state_next = mrc_pkg::MRC_ST_FAULT;
                end
            end
            mrc_pkg::MRC_ST_FAULT: begin
                if (lvr_fire || wdt_full || fault_done) begin
                    state_next = mrc_pkg::MRC_ST_HOLD;
                end
            end
            mrc_pkg::MRC_ST_HOLD: begin
                if (!ls_filt_reg && cnt_hit(cnt_reg, POR_CYCLES)) begin
                    state_next = mrc_pkg::MRC_ST_RUN;
                end
            end
        endcase
    end

    // Counters
    always_comb begin
        cnt_next = '0;
        if ((state_reg == state_next) && !running &&
            !(state_reg == mrc_pkg::MRC_ST_HOLD && ls_filt_reg)) begin
            cnt_next = cnt_reg + `MRC_CNT_W'(1);
        end
        qual_next = '0;
        if (mon_active && !lvr_fire) begin
            qual_next = qual_reg + `MRC_CNT_W'(1);
        end
        rc_cnt_next = '0;
        if (state_reg == mrc_pkg::MRC_ST_FAULT) begin
            rc_cnt_next = rc_edge ? rc_cnt_reg + 2'd1 : rc_cnt_reg;
        end
    end

    // merged reset, asserted by hresetn or on hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= mrc_pkg::MRC_ST_POR;
            cnt_reg <= '0;
            qual_reg <= '0;
            rc_cnt_reg <= 2'd0;
            fault_src_reg <= 1'b0;
            core_rst_n_reg <= 1'b0;
            ctx_clear_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            qual_reg <= qual_next;
            rc_cnt_reg <= rc_cnt_next;
            if (fault_req) begin
                fault_src_reg <= wdt_ctrl_fault & code_ok(thresh_reg);
            end
            // core held in reset clears PC, IRQs, timers
            core_rst_n_reg <= (state_next == mrc_pkg::MRC_ST_RUN) ||
                              (state_next == mrc_pkg::MRC_ST_FAULT);
            // sleep time-out clears only PC and stack
            ctx_clear_reg <= wdt_sleep & ~lvr_fire;
        end
    end

    // Flags and registers
    always_comb begin
        istat_set = '0;
        istat_set[`MRC_IRQ_LOWSUP] = lvr_fire;
        istat_set[`MRC_IRQ_FAULT] = fault_load & ~fault_src_reg;
        istat_set[`MRC_IRQ_WDT] = wdt_timeout;
        istat_set[`MRC_IRQ_WDTCTL] = fault_load & fault_src_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lowsup_reg <= 1'b0;
            fault_reg <= 1'b0;
            wdtctl_reg <= 1'b0;
            to_reg <= 1'b0;
            pdf_reg <= 1'b0;
            istat_reg <= '0;
            imask_reg <= '0;
        end else begin
            lowsup_reg <= sticky(lowsup_reg, lvr_fire,
                                 wr_cause & ~hwdata[`MRC_CAUSE_LOWSUP]);
            fault_reg <= sticky(fault_reg, fault_load & ~fault_src_reg,
                                wr_cause & ~hwdata[`MRC_CAUSE_FAULT]);
            wdtctl_reg <= sticky(wdtctl_reg, fault_load & fault_src_reg,
                                 wr_cause & ~hwdata[`MRC_CAUSE_WDTCTL]);
            to_reg <= to_reg | wdt_timeout;
            pdf_reg <= sticky(pdf_reg, halt_exec | wdt_sleep, clr_wdt);
            istat_reg <= istat_set |
                (istat_reg & ~(wr_istat ? hwdata[`MRC_IRQ_W-1:0] : '0));
            if (wr_imask) begin
                imask_reg <= hwdata[`MRC_IRQ_W-1:0];
            end
        end
    end

    // Registers preset again by every full reset, except the threshold code on a low-supply reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thresh_reg <= `MRC_THRESH_POR;
            sysclk_reg <= 1'b0;
            pdata_reg <= `MRC_PORT_POR;
            pdir_reg <= `MRC_PORT_POR;
        end else if (enter_hold) begin
            // low supply keeps the code, others restore it
            if (!keep_thresh) begin
                thresh_reg <= `MRC_THRESH_POR;
            end
            sysclk_reg <= 1'b0;
            pdata_reg <= `MRC_PORT_POR;
            pdir_reg <= `MRC_PORT_POR;
        end else begin
            if (wr_thresh) begin
                thresh_reg <= hwdata[7:0];
            end
            if (wr_cause) begin
                sysclk_reg <= hwdata[`MRC_CAUSE_SYSCLK];
            end
            if (wr_pdata) begin
                pdata_reg <= hwdata[7:0];
            end
            if (wr_pdir) begin
                pdir_reg <= hwdata[7:0];
            end
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `MRC_ZERO32;
        unique case (dp_addr_reg)
            `MRC_ADDR_CAUSE: begin
                rd_mux[`MRC_CAUSE_SYSCLK] = sysclk_reg;
                rd_mux[`MRC_CAUSE_LOWSUP] = lowsup_reg;
                rd_mux[`MRC_CAUSE_FAULT] = fault_reg;
                rd_mux[`MRC_CAUSE_WDTCTL] = wdtctl_reg;
            end
            `MRC_ADDR_THRESH: rd_mux[7:0] = thresh_reg;
            `MRC_ADDR_STATUS: begin
                rd_mux[`MRC_STATUS_TO] = to_reg;
                rd_mux[`MRC_STATUS_PDF] = pdf_reg;
            end
            `MRC_ADDR_IRQ_STAT: rd_mux[`MRC_IRQ_W-1:0] = istat_reg;
            `MRC_ADDR_IRQ_MASK: rd_mux[`MRC_IRQ_W-1:0] = imask_reg;
            `MRC_ADDR_PORT_DATA: rd_mux[7:0] = pdata_reg;
            `MRC_ADDR_PORT_DIR: rd_mux[7:0] = pdir_reg;
            default: rd_mux = `MRC_ZERO32;
        endcase
    end

    // Bus phases; a read takes one wait state so hrdata comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg <= 1'b0;
            dp_rd_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            hrdata_reg <= `MRC_ZERO32;
        end else begin
            dp_wr_reg <= ap_valid & hwrite;
            dp_rd_reg <= ap_valid & ~hwrite;
            if (ap_valid) begin
                dp_addr_reg <= haddr[7:0];
            end
            if (dp_rd_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    assign hreadyout = ~dp_rd_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign irq = |(istat_reg & imask_reg);
    assign core_rst_n = core_rst_n_reg;
    assign ctx_clear = ctx_clear_reg;
    assign threshold_code = thresh_reg;
    assign idle_sysclk_keep = sysclk_reg;
    assign port_data = pdata_reg;
    assign port_dir = pdir_reg;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_por_release;
        $rose(core_rst_n_reg) |-> 32'($past(cnt_reg)) + 32'd1 >= POR_CYCLES;
    endproperty
    a_por_release: assert property (p_por_release)
        else $error("core reset released before the delay");

    property p_lowsup_clear;
        $fell(lowsup_reg) |->
            $past(wr_cause) && !$past(hwdata[`MRC_CAUSE_LOWSUP]);
    endproperty
    a_lowsup_clear: assert property (p_lowsup_clear)
        else $error("low-supply flag cleared without a zero write");

    property p_fault_reset;
        (fault_load && !fault_src_reg) |=>
            fault_reg && thresh_reg == `MRC_THRESH_POR && !core_rst_n_reg;
    endproperty
    a_fault_reset: assert property (p_fault_reset)
        else $error("code fault did not reset and restore");

    property p_fault_clear;
        $fell(fault_reg) |->
            $past(wr_cause) && !$past(hwdata[`MRC_CAUSE_FAULT]);
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault flag cleared without a zero write");

    property p_lvr_keep;
        lvr_fire |=> thresh_reg == $past(thresh_reg) && lowsup_reg &&
                     !core_rst_n_reg;
    endproperty
    a_lvr_keep: assert property (p_lvr_keep)
        else $error("low-supply reset lost the threshold code");

    property p_qualify;
        lvr_fire |-> $past(ls_filt_reg) && 32'(qual_reg) + 32'd1 >= QUAL_CYCLES;
    endproperty
    a_qualify: assert property (p_qualify)
        else $error("low supply reset before qualifying time");

    property p_sleep_off;
        sleep_mode [*2] |-> qual_reg == '0 && !lvr_fire;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("monitor active in power-down");

    property p_wdt_run;
        (wdt_full && !lvr_fire) |=>
            to_reg && !core_rst_n_reg && pdf_reg == $past(pdf_reg);
    endproperty
    a_wdt_run: assert property (p_wdt_run)
        else $error("run time-out reset wrong");

    property p_wdt_sleep;
        (wdt_sleep && !lvr_fire) |=>
            ctx_clear_reg && core_rst_n_reg && to_reg && pdf_reg
            ##1 !ctx_clear_reg;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep)
        else $error("sleep time-out did not clear context only");

    property p_ports_preset;
        $fell(core_rst_n_reg) |->
            port_data == `MRC_PORT_POR && port_dir == `MRC_PORT_POR;
    endproperty
    a_ports_preset: assert property (p_ports_preset)
        else $error("ports not preset on reset");

    property p_code_ok;
        (state_reg == mrc_pkg::MRC_ST_RUN && code_ok(thresh_reg) &&
         !wdt_ctrl_fault) |=> state_reg != mrc_pkg::MRC_ST_FAULT;
    endproperty
    a_code_ok: assert property (p_code_ok)
        else $error("valid code started a fault reset");

    property p_halt_pdf;
        (halt_exec && !clr_wdt) |=> pdf_reg;
    endproperty
    a_halt_pdf: assert property (p_halt_pdf)
        else $error("halt did not set power-down flag");

    c_por: cover property ($rose(core_rst_n_reg));
    c_lvr: cover property (lvr_fire ##[1:1000] $rose(core_rst_n_reg));
    c_fault: cover property (fault_load);
    c_sleep: cover property (wdt_sleep);

endmodule : mrc_reset_ctrl

// >>> mcu_reset_controller_tb_top.sv
// Self-checking bench for the reset sequencer: AHB-Lite register access,
// every reset source, cause and status flags, interrupt and presets.
// Assumes mrc_params.svh on the include path and shortened counts.
`timescale 1ns/100ps
`include "mrc_params.svh"
module mcu_reset_controller_tb_top;
    localparam int unsigned POR_CYC = 50;
    localparam int unsigned QUAL_CYC = 10;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata;
    logic low_supply_in = 1'b0;
    logic slow_rc = 1'b0;
    logic wdt_timeout = 1'b0;
    logic wdt_ctrl_fault = 1'b0;
    logic sleep_mode = 1'b0;
    logic halt_exec = 1'b0;
    logic clr_wdt = 1'b0;
    logic core_rst_n, ctx_clear, idle_sysclk_keep;
    logic [7:0] threshold_code, port_data, port_dir, code;
    logic [31:0] seed;
    int miscompares = 0;
    int comparisons = 0;

    assign hready = hreadyout;
    always #25 hclk = ~hclk;
    always #400 slow_rc = ~slow_rc;

    mrc_reset_ctrl #(.POR_CYCLES(POR_CYC), .QUAL_CYCLES(QUAL_CYC))
        mrc_reset_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .low_supply_in(low_supply_in), .slow_internal_rc(slow_rc),
        .wdt_timeout(wdt_timeout), .wdt_ctrl_fault(wdt_ctrl_fault),
        .sleep_mode(sleep_mode), .halt_exec(halt_exec), .clr_wdt(clr_wdt),
        .core_rst_n(core_rst_n), .ctx_clear(ctx_clear),
        .threshold_code(threshold_code), .idle_sysclk_keep(idle_sysclk_keep),
        .port_data(port_data), .port_dir(port_dir));

    function automatic logic [31:0] status_exp(input logic to, input logic pd);
        return {26'h0, to, pd, 4'h0};
    endfunction : status_exp

    function automatic logic is_legal(input logic [7:0] c);
        return c == `MRC_CODE_2V10 || c == `MRC_CODE_2V55 ||
            c == `MRC_CODE_3V15 || c == `MRC_CODE_3V80;
    endfunction : is_legal

    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One single word transfer; entered and left just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        hsize <= `MRC_HSIZE_WORD;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
        @(posedge hclk);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'b1, a, d, unused);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a,
            input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, `MRC_ZERO32, v);
        check(what, exp, v);
    endtask : rd_chk

    task automatic wait_rst(input logic lvl, input int unsigned lim);
        int unsigned n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (core_rst_n !== lvl && n < lim);
        check("core_rst_n", {31'h0, lvl}, {31'h0, core_rst_n});
        @(posedge hclk);
    endtask : wait_rst

    // One-edge core event: 0 halt, 1 watchdog clear, 2 control fault,
    // 3 time-out; only the chosen signal is driven
    task automatic pulse(input int sel);
        for (int v = 1; v >= 0; v--) begin
            case (sel)
                0: halt_exec <= 1'(v);
                1: clr_wdt <= 1'(v);
                2: wdt_ctrl_fault <= 1'(v);
                default: wdt_timeout <= 1'(v);
            endcase
            if (v == 1) begin
                @(posedge hclk);
            end
        end
    endtask : pulse

    task automatic end_test(input string name);
        $display("test %s finished, %0d miscompares", name, miscompares);
    endtask : end_test

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    initial begin
        #1_000_000;
        miscompares++;
        test_done();
    end

    initial begin
        seed = 32'h4a35;
        repeat (3) @(posedge hclk);
        check("por_code", 32'h55, {24'h0, threshold_code});
        check("por_port", 32'hffff, {port_data, port_dir});
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (POR_CYC - 3) @(posedge hclk);
        check("rst_held", 32'h0, {31'h0, core_rst_n});
        wait_rst(1'b1, 10);
        rd_chk("status_por", `MRC_ADDR_STATUS, status_exp(0, 0));
        rd_chk("thresh_por", `MRC_ADDR_THRESH, 32'h55);
        rd_chk("pdata_por", `MRC_ADDR_PORT_DATA, 32'hff);
        rd_chk("pdir_por", `MRC_ADDR_PORT_DIR, 32'hff);
        wr(8'h1c, 32'h5a);
        rd_chk("unmapped", 8'h1c, 32'h0);
        for (int i = 0; i < 4; i++) begin
            code = i == 0 ? `MRC_CODE_3V80 : i == 1 ? `MRC_CODE_3V15 :
                i == 2 ? `MRC_CODE_2V55 : `MRC_CODE_2V10;
            wr(`MRC_ADDR_THRESH, {24'h0, code});
            rd_chk("thresh_rw", `MRC_ADDR_THRESH, {24'h0, code});
            check("code_out", {24'h0, code}, {24'h0, threshold_code});
        end
        repeat (20) @(posedge hclk);
        check("no_fault", 32'h1, {31'h0, core_rst_n});
        end_test("registers");

        low_supply_in <= 1'b1;
        repeat (QUAL_CYC - 3) @(posedge hclk);
        low_supply_in <= 1'b0;
        repeat (20) @(posedge hclk);
        check("short_low", 32'h1, {31'h0, core_rst_n});
        wr(`MRC_ADDR_THRESH, {24'h0, `MRC_CODE_3V80});
        wr(`MRC_ADDR_PORT_DATA, {24'h0, 8'($random(seed))});
        low_supply_in <= 1'b1;
        wait_rst(1'b0, QUAL_CYC + 10);
        low_supply_in <= 1'b0;
        wait_rst(1'b1, POR_CYC + 10);
        rd_chk("cause_low", `MRC_ADDR_CAUSE, 32'h04);
        rd_chk("thresh_kept", `MRC_ADDR_THRESH, 32'haa);
        rd_chk("status_low", `MRC_ADDR_STATUS, status_exp(0, 0));
        check("pdata_low", 32'hff, {24'h0, port_data});
        check("irq_masked", 32'h0, {31'h0, irq});
        wr(`MRC_ADDR_IRQ_MASK, 32'h0f);
        @(negedge hclk);
        check("irq_on", 32'h1, {31'h0, irq});
        @(posedge hclk);
        wr(`MRC_ADDR_IRQ_STAT, 32'h01);
        @(negedge hclk);
        check("irq_off", 32'h0, {31'h0, irq});
        @(posedge hclk);
        end_test("low_supply");

        pulse(0);
        rd_chk("status_halt", `MRC_ADDR_STATUS, status_exp(0, 1));
        sleep_mode <= 1'b1;
        low_supply_in <= 1'b1;
        repeat (QUAL_CYC * 3) @(posedge hclk);
        low_supply_in <= 1'b0;
        check("sleep_low", 32'h1, {31'h0, core_rst_n});
        pulse(3);
        @(negedge hclk);
        check("ctx_clear", 32'h3, {30'h0, ctx_clear, core_rst_n});
        @(negedge hclk);
        check("ctx_once", 32'h1, {30'h0, ctx_clear, core_rst_n});
        @(posedge hclk);
        rd_chk("status_slp", `MRC_ADDR_STATUS, status_exp(1, 1));
        rd_chk("thresh_slp", `MRC_ADDR_THRESH, 32'haa);
        sleep_mode <= 1'b0;
        pulse(1);
        rd_chk("status_clr", `MRC_ADDR_STATUS, status_exp(1, 0));
        end_test("sleep");

        wr(`MRC_ADDR_THRESH, {24'h0, `MRC_CODE_3V15});
        wr(`MRC_ADDR_PORT_DIR, {24'h0, 8'($random(seed))});
        pulse(0);
        pulse(3);
        @(negedge hclk);
        check("wdt_rst", 32'h0, {31'h0, core_rst_n});
        @(posedge hclk);
        wait_rst(1'b1, POR_CYC + 10);
        rd_chk("status_wdt", `MRC_ADDR_STATUS, status_exp(1, 1));
        rd_chk("thresh_wdt", `MRC_ADDR_THRESH, 32'h55);
        rd_chk("pdir_wdt", `MRC_ADDR_PORT_DIR, 32'hff);
        end_test("watchdog");

        do code = 8'($random(seed)); while (is_legal(code));
        wr(`MRC_ADDR_THRESH, {24'h0, code});
        wait_rst(1'b0, 300);
        wait_rst(1'b1, POR_CYC + 10);
        rd_chk("cause_fault", `MRC_ADDR_CAUSE, 32'h06);
        rd_chk("thresh_fault", `MRC_ADDR_THRESH, 32'h55);
        pulse(2);
        wait_rst(1'b0, 300);
        wait_rst(1'b1, POR_CYC + 10);
        rd_chk("cause_wctl", `MRC_ADDR_CAUSE, 32'h07);
        rd_chk("irq_stat", `MRC_ADDR_IRQ_STAT, 32'h0e);
        wr(`MRC_ADDR_IRQ_STAT, 32'h0f);
        rd_chk("irq_clr", `MRC_ADDR_IRQ_STAT, 32'h0);
        wr(`MRC_ADDR_CAUSE, 32'h80);
        rd_chk("cause_clr", `MRC_ADDR_CAUSE, 32'h80);
        check("sysclk_keep", 32'h1, {31'h0, idle_sysclk_keep});
        end_test("fault");

        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check("por_again", 32'h0, {31'h0, core_rst_n});
        hresetn <= 1'b1;
        wait_rst(1'b1, POR_CYC + 10);
        rd_chk("status_por2", `MRC_ADDR_STATUS, status_exp(0, 0));
        end_test("power_on");
        test_done();
    end
endmodule : mcu_reset_controller_tb_top
